/* src/rzf_cfg.svh */
`ifndef RZF_CFG_SVH
`define RZF_CFG_SVH
`define RZF_ADR_CTRL 8'h00
`define RZF_ADR_STAT 8'h04
`define RZF_ADR_ZSTORE 8'h08
`define RZF_ADR_READ 8'h0C
`define RZF_FW_PAGE 3'h1
`define RZF_CTRL_ZKEY 0
`define RZF_CTRL_FKEY 1
`define RZF_CTRL_RECALL 2
`define RZF_CTRL_INTEN 3
`define RZF_CTRL_ONESHOT 4
`define RZF_INTEN_RST 1'b1
`define RZF_FW_RST 7'h0A
`define RZF_FW_MIN 7'h01
`define RZF_FW_MAX 7'h63
`define RZF_FWIN_6D 24'h002710
`define RZF_FWIN_5D 24'h0003E8
`define RZF_FWIN_4D 24'h000064
`define RZF_FWIN_3D 24'h00000A
`define RZF_DISP_LIM 32'h002191C0
`define RZF_HAZ_R3 32'h00061A80
`define RZF_HAZ_R4 32'h00009C40
`define RZF_RNG_HV 3'h3
`define RZF_RNG_TOP 3'h4
`define RZF_RES_TOP 2'h3
`define RZF_TC_SETTLE 2'h3
`define RZF_BLINK_HALF_MS 250
`define RZF_CLK_MHZ 100
`endif

/* src/rzf_pkg.sv */
package rzf_pkg;
   typedef logic signed [23:0] rzf_cnt_t;
   typedef logic [6:0] rzf_wt_t;
   typedef enum logic [2:0]
   {
      FN_DC_VOLTS, FN_AC_VOLTS, FN_OHMS_2W, FN_OHMS_4W,
      FN_DC_CURRENT, FN_AC_CURRENT, FN_TEMP, FN_AC_DC
   } rzf_func_t;
   typedef enum logic {ZS_IDLE, ZS_WAIT} rzf_zst_t;
endpackage

/* src/rzf_avg_if.sv */
`timescale 1ns/1ns
interface rzf_avg_if;
   logic in_valid;
   logic in_over;
   logic enable;
   logic restart;
   rzf_pkg::rzf_cnt_t in_data;
   rzf_pkg::rzf_cnt_t window;
   rzf_pkg::rzf_wt_t weight;
   logic out_valid;
   logic out_over;
   logic bypass;
   rzf_pkg::rzf_cnt_t out_data;
   modport src(output in_valid, in_over, enable, restart, in_data, window,
      weight, input out_valid, out_over, bypass, out_data);
   modport filt(input in_valid, in_over, enable, restart, in_data, window,
      weight, output out_valid, out_over, bypass, out_data);
endinterface

/* src/rzf_avg.sv */
`timescale 1ns/1ns
module rzf_avg
(
   input wire logic clk,
   input wire logic rst,
   rzf_avg_if.filt f
);
   import rzf_pkg::*;
   logic signed [24:0] diff;
   logic signed [24:0] mag;
   logic signed [24:0] step;
   logic primed_reg;
   logic primed_ok;
   logic jump;
   rzf_cnt_t avg_reg;
   logic vld_reg;
   logic ovr_reg;
   logic byp_reg;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   assign diff = 25'(f.in_data) - 25'(avg_reg);
   assign mag = diff[24] ? -diff : diff;
   assign step = diff / $signed({18'h00000, f.weight});
   assign primed_ok = primed_reg & ~f.restart;
   assign jump = mag > 25'(f.window);
   assign f.out_data = avg_reg;
   assign f.out_valid = vld_reg;
   assign f.out_over = ovr_reg;
   assign f.bypass = byp_reg;

   always_ff @(posedge clk)
   begin
      if (rst || f.restart)
         primed_reg <= 1'b0;
      else if (f.in_valid)
         primed_reg <= f.enable & ~f.in_over;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         avg_reg <= '0;
         vld_reg <= 1'b0;
         ovr_reg <= 1'b0;
         byp_reg <= 1'b0;
      end
      else
      begin
         vld_reg <= f.in_valid;
         byp_reg <= 1'b0;
         if (f.in_valid)
         begin
            ovr_reg <= f.in_over;
            if (!f.enable || f.in_over || !primed_ok || jump)
            begin
               // out-of-window reading is shown as is and restarts averaging
               avg_reg <= f.in_data;
               byp_reg <= f.enable & ~f.in_over & primed_ok & jump;
            end
            else
               avg_reg <= avg_reg + step[23:0];
         end
      end
   end

   chk_window_bypass: assert property (
      f.in_valid && f.enable && !f.in_over && primed_ok && jump
      |=> avg_reg == $past(f.in_data) && byp_reg)
      else $error("out-of-window reading not passed through");

   chk_avg_step: assert property (
      f.in_valid && f.enable && !f.in_over && primed_ok && !jump
      |=> avg_reg == $past(avg_reg) + $past(step[23:0]))
      else $error("weighted average step wrong");
endmodule

/* src/rzf_top.sv */
// Functional notes
// - hazard flag at 40 V or more
// - zero on: output is signal minus baseline
// - zero off cancels this function only; store kept
// - enabling zero replaces store; other functions untouched
// - first in-range conversion after enable becomes baseline, stored
// - range below baseline reports overrange
// - zero lamp blinks until baseline captured
// - filter weight defaults 10, limits 1..99
// - one filter weight kept per function
// - filter key toggles filter; lamp lit when on
// - lamp blinks three time constants after trigger
// - continuous: window jump blinks one constant
// - average moves by difference over weight
// - out-of-window reading shown, averaging restarts
// - front window 10000/1000/100/10 counts by resolution
// - internal filter on after reset, bus switchable
// - internal filter only at 5.5/6.5 listed cases
// - internal filter weight and window table
// - internal filter uses same window bypass
// - filter lamp follows front filter only
// - one-shot holds output three summed constants
// - zero key captures reading as baseline
// - baseline same value on every range
// - display limit 2200000, doubled with zero
//
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ns
`include "rzf_cfg.svh"
module rzf_top
#(
   parameter int BLINK_HALF_CYC = `RZF_BLINK_HALF_MS * 1000 * `RZF_CLK_MHZ
)
(
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic CONV_VALID,
   input wire logic signed [23:0] CONV_DATA,
   input wire logic CONV_OVER,
   input wire logic CONV_TRIG,
   input wire rzf_pkg::rzf_func_t FUNC_SEL,
   input wire logic [2:0] RANGE_SEL,
   input wire logic [1:0] RES_SEL,
   output logic OUT_VALID,
   output logic signed [23:0] OUT_DATA,
   output logic OUT_OVER,
   output logic HAZARD,
   output logic ZERO_LED,
   output logic FILT_LED
);
   import rzf_pkg::*;

   function automatic logic signed [31:0] p10(input int k);
      case (k)
         1: p10 = 32'h0000000A;
         2: p10 = 32'h00000064;
         3: p10 = 32'h000003E8;
         4: p10 = 32'h00002710;
         5: p10 = 32'h000186A0;
         6: p10 = 32'h000F4240;
         7: p10 = 32'h00989680;
         default: p10 = 32'h00000001;
      endcase
   endfunction

   // internal filter table: weight 0 means not filtered
   function automatic logic [30:0] itab(input rzf_func_t fn,
      input logic [2:0] rng, input logic [1:0] res);
      itab = '0;
      if (res == 2'h2)
      begin
         if ((fn == FN_DC_VOLTS && rng == 3'h0) || fn == FN_DC_CURRENT)
            itab = {7'h05, 24'h000006};
         else if (fn == FN_OHMS_2W || fn == FN_OHMS_4W)
            itab = (rng < 3'h4) ? {7'h05, 24'h000006} :
               {7'h0A, 24'h000028};
      end
      else if (res == 2'h3)
      begin
         if (fn == FN_DC_VOLTS)
            itab = (rng == 3'h0) ? {7'h23, 24'h00003C} :
               {7'h0A, 24'h000014};
         else if (fn == FN_OHMS_2W || fn == FN_OHMS_4W)
            itab = (rng < 3'h4) ? {7'h28, 24'h00003C} :
               {7'h28, 24'h000190};
         else if (fn == FN_AC_VOLTS)
            itab = {7'h0A, 24'h000014};
      end
   endfunction

   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);

   // register bus
   logic ack_reg;
   logic [31:0] dat_reg;
   logic [31:0] rd_mux;
   logic wr_en;
   logic ctrl_wr;
   logic zkey;
   logic fkey;
   logic recall;
   logic fw_hit;
   assign wr_en = WB_CYC_I & WB_STB_I & WB_WE_I & ack_reg;
   assign ctrl_wr = wr_en & WB_SEL_I[0] & (WB_ADR_I == `RZF_ADR_CTRL);
   assign zkey = ctrl_wr & WB_DAT_I[`RZF_CTRL_ZKEY];
   assign fkey = ctrl_wr & WB_DAT_I[`RZF_CTRL_FKEY];
   assign recall = ctrl_wr & WB_DAT_I[`RZF_CTRL_RECALL];
   assign fw_hit = WB_ADR_I[7:5] == `RZF_FW_PAGE && WB_ADR_I[1:0] == 2'h0;
   assign WB_ACK_O = ack_reg;
   assign WB_DAT_O = dat_reg;

   // control state
   logic filt_en_reg;
   logic int_en_reg;
   logic oneshot_reg;
   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         filt_en_reg <= 1'b0;
         int_en_reg <= `RZF_INTEN_RST;
         oneshot_reg <= 1'b0;
      end
      else
      begin
         if (fkey)
            filt_en_reg <= ~filt_en_reg;
         if (ctrl_wr)
         begin
            int_en_reg <= WB_DAT_I[`RZF_CTRL_INTEN];
            oneshot_reg <= WB_DAT_I[`RZF_CTRL_ONESHOT];
         end
      end
   end

   rzf_wt_t fw_reg [8];
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_fw
         always_ff @(posedge CORE_CLK)
         begin
            if (SYS_RST)
               fw_reg[gi] <= `RZF_FW_RST;
            else if (wr_en && WB_SEL_I[0] && fw_hit &&
               WB_ADR_I[4:2] == 3'(gi) &&
               WB_DAT_I[6:0] >= `RZF_FW_MIN && WB_DAT_I[6:0] <= `RZF_FW_MAX)
               fw_reg[gi] <= WB_DAT_I[6:0];
         end
      end
   endgenerate

   // zero baselines, one per function
   rzf_func_t fn;
   rzf_zst_t zst_reg;
   rzf_func_t zfn_reg;
   logic [7:0] zon_reg;
   rzf_cnt_t base_reg [8];
   logic [2:0] brng_reg [8];
   logic [1:0] bres_reg [8];
   rzf_cnt_t zstore_reg;
   logic cap;
   logic zwait;
   logic zact;
   assign fn = FUNC_SEL;
   assign zwait = zst_reg == ZS_WAIT && zfn_reg == fn;
   assign zact = zon_reg[fn] & ~zwait;
   assign cap = zst_reg == ZS_WAIT && !zkey && CONV_VALID && !CONV_OVER &&
      fn == zfn_reg;

   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         zst_reg <= ZS_IDLE;
         zfn_reg <= FN_DC_VOLTS;
         zon_reg <= '0;
         zstore_reg <= '0;
         for (int i = 0; i < 8; i++)
         begin
            base_reg[i] <= '0;
            brng_reg[i] <= '0;
            bres_reg[i] <= '0;
         end
      end
      else
      begin
         if (wr_en && WB_ADR_I == `RZF_ADR_ZSTORE)
            for (int i = 0; i < 3; i++)
               if (WB_SEL_I[i])
                  zstore_reg[8*i +: 8] <= WB_DAT_I[8*i +: 8];
         unique case (zst_reg)
            ZS_IDLE:
               if (zkey && zon_reg[fn])
                  zon_reg[fn] <= 1'b0;
               else if (zkey)
               begin
                  zon_reg[fn] <= 1'b1;
                  zst_reg <= ZS_WAIT;
                  zfn_reg <= fn;
               end
               else if (recall)
               begin
                  zon_reg[fn] <= 1'b1;
                  base_reg[fn] <= zstore_reg;
                  brng_reg[fn] <= RANGE_SEL;
                  bres_reg[fn] <= RES_SEL;
               end
            ZS_WAIT:
               if (zkey)
               begin
                  zon_reg[zfn_reg] <= 1'b0;
                  zst_reg <= ZS_IDLE;
               end
               else if (cap)
               begin
                  // capture wins over a bus write to the store
                  base_reg[fn] <= CONV_DATA;
                  brng_reg[fn] <= RANGE_SEL;
                  bres_reg[fn] <= RES_SEL;
                  zstore_reg <= CONV_DATA;
                  zst_reg <= ZS_IDLE;
               end
         endcase
      end
   end

   // baseline rescaled from its capture range and resolution
   int sh;
   logic signed [31:0] bsc;
   logic signed [31:0] zdiff;
   logic signed [31:0] zmag;
   logic signed [31:0] lim;
   logic signed [31:0] rmag;
   logic signed [31:0] thr;
   logic base_bad;
   logic volts;
   assign sh = int'(RANGE_SEL) - int'(brng_reg[fn]) + int'(bres_reg[fn]) -
      int'(RES_SEL);
   assign bsc = (sh >= 0) ? 32'(base_reg[fn]) / p10(sh) :
      32'(base_reg[fn]) * p10(-sh);
   assign base_bad = RANGE_SEL < brng_reg[fn];
   assign zdiff = zact ? 32'(CONV_DATA) - bsc : 32'(CONV_DATA);
   assign zmag = zdiff[31] ? -zdiff : zdiff;
   assign lim = (zact ? 32'(2) * `RZF_DISP_LIM : `RZF_DISP_LIM) /
      p10(3 - int'(RES_SEL));
   assign rmag = CONV_DATA[23] ? -32'(CONV_DATA) : 32'(CONV_DATA);
   assign volts = (fn == FN_DC_VOLTS || fn == FN_AC_VOLTS ||
      fn == FN_AC_DC) && RANGE_SEL >= `RZF_RNG_HV;
   assign thr = (RANGE_SEL == `RZF_RNG_TOP ? `RZF_HAZ_R4 : `RZF_HAZ_R3) /
      p10(3 - int'(RES_SEL));

   logic s0_valid_reg;
   logic s0_over_reg;
   rzf_cnt_t s0_data_reg;
   logic haz_reg;
   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         s0_valid_reg <= 1'b0;
         s0_over_reg <= 1'b0;
         s0_data_reg <= '0;
         haz_reg <= 1'b0;
      end
      else
      begin
         s0_valid_reg <= CONV_VALID;
         if (CONV_VALID)
         begin
            // the capturing reading itself shows zero
            s0_data_reg <= cap ? '0 : zdiff[23:0];
            s0_over_reg <= CONV_OVER | (zact & base_bad) |
               (zmag > lim);
            haz_reg <= volts & (CONV_OVER | rmag >= thr);
         end
      end
   end

   // filter chain: internal stage then front panel stage
   logic [2:0] prev_rng_reg;
   logic [1:0] prev_res_reg;
   rzf_func_t prev_fn_reg;
   logic cfg_chg;
   logic [30:0] it;
   logic int_act;
   assign cfg_chg = prev_fn_reg != fn || prev_rng_reg != RANGE_SEL ||
      prev_res_reg != RES_SEL;
   assign it = itab(fn, RANGE_SEL, RES_SEL);
   assign int_act = int_en_reg && it[30:24] != 7'h00;

   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         prev_fn_reg <= FN_DC_VOLTS;
         prev_rng_reg <= '0;
         prev_res_reg <= '0;
      end
      else
      begin
         prev_fn_reg <= fn;
         prev_rng_reg <= RANGE_SEL;
         prev_res_reg <= RES_SEL;
      end
   end

   rzf_avg_if ifi();
   rzf_avg_if ifr();
   assign ifi.in_valid = s0_valid_reg;
   assign ifi.in_over = s0_over_reg;
   assign ifi.in_data = s0_data_reg;
   assign ifi.enable = int_act;
   assign ifi.restart = cfg_chg;
   assign ifi.weight = it[30:24];
   assign ifi.window = it[23:0];
   assign ifr.in_valid = ifi.out_valid;
   assign ifr.in_over = ifi.out_over;
   assign ifr.in_data = ifi.out_data;
   assign ifr.enable = filt_en_reg;
   assign ifr.restart = cfg_chg;
   assign ifr.weight = fw_reg[fn];
   always_comb
   begin
      unique case (RES_SEL)
         2'h3: ifr.window = `RZF_FWIN_6D;
         2'h2: ifr.window = `RZF_FWIN_5D;
         2'h1: ifr.window = `RZF_FWIN_4D;
         2'h0: ifr.window = `RZF_FWIN_3D;
      endcase
   end

   rzf_avg u_int (.clk(CORE_CLK), .rst(SYS_RST), .f(ifi.filt));
   rzf_avg u_front (.clk(CORE_CLK), .rst(SYS_RST), .f(ifr.filt));

   // settling count since trigger, blink count in readings
   logic [9:0] settle_reg;
   logic [9:0] need;
   logic [9:0] blink_reg;
   logic settled;
   assign need = `RZF_TC_SETTLE * ((filt_en_reg ? 10'(fw_reg[fn]) : 10'h000)
      + (int_act ? 10'(it[30:24]) : 10'h000));
   assign settled = settle_reg + 10'h001 >= need;

   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
         settle_reg <= '0;
      else if (CONV_TRIG)
         settle_reg <= '0;
      else if (ifr.out_valid && settle_reg != 10'h3FF)
         settle_reg <= settle_reg + 10'h001;
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST || !filt_en_reg)
         blink_reg <= '0;
      else if (CONV_TRIG)
         blink_reg <= `RZF_TC_SETTLE * 10'(fw_reg[fn]);
      else if (ifr.bypass && !oneshot_reg &&
         blink_reg < 10'(fw_reg[fn]))
         blink_reg <= 10'(fw_reg[fn]);
      else if (ifr.out_valid && blink_reg != 10'h000)
         blink_reg <= blink_reg - 10'h001;
   end

   logic [31:0] div_reg;
   logic phase_reg;
   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST || div_reg == 32'(BLINK_HALF_CYC - 1))
         div_reg <= '0;
      else
         div_reg <= div_reg + 32'h00000001;
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
         phase_reg <= 1'b0;
      else if (div_reg == 32'(BLINK_HALF_CYC - 1))
         phase_reg <= ~phase_reg;
   end

   // outputs
   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         OUT_VALID <= 1'b0;
         OUT_DATA <= '0;
         OUT_OVER <= 1'b0;
         HAZARD <= 1'b0;
         ZERO_LED <= 1'b0;
         FILT_LED <= 1'b0;
      end
      else
      begin
         OUT_VALID <= ifr.out_valid & (~oneshot_reg | settled);
         if (ifr.out_valid)
         begin
            OUT_DATA <= ifr.out_data;
            OUT_OVER <= ifr.out_over;
         end
         HAZARD <= haz_reg;
         ZERO_LED <= zon_reg[fn] & (~zwait | phase_reg);
         FILT_LED <= filt_en_reg & (blink_reg == 10'h000 | phase_reg);
      end
   end

   // register read and acknowledge
   always_comb
   begin
      rd_mux = '0;
      if (WB_ADR_I == `RZF_ADR_CTRL)
      begin
         rd_mux[`RZF_CTRL_INTEN] = int_en_reg;
         rd_mux[`RZF_CTRL_ONESHOT] = oneshot_reg;
      end
      else if (WB_ADR_I == `RZF_ADR_STAT)
         rd_mux[7:0] = {1'b0, HAZARD, settled, int_act, filt_en_reg, zwait,
            zact, zon_reg[fn]};
      else if (WB_ADR_I == `RZF_ADR_ZSTORE)
         rd_mux = 32'(zstore_reg);
      else if (WB_ADR_I == `RZF_ADR_READ)
         rd_mux = 32'(OUT_DATA);
      else if (fw_hit)
         rd_mux[6:0] = fw_reg[WB_ADR_I[4:2]];
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         ack_reg <= 1'b0;
         dat_reg <= '0;
      end
      else
      begin
         ack_reg <= WB_CYC_I & WB_STB_I & ~ack_reg;
         if (WB_CYC_I && WB_STB_I && !ack_reg)
            dat_reg <= rd_mux;
      end
   end

   chk_hazard_flag: assert property (
      CONV_VALID && fn == FN_DC_VOLTS && RANGE_SEL == `RZF_RNG_TOP &&
      RES_SEL == 2'h0 && rmag >= `RZF_HAZ_R4 / 1000 |=> ##1 HAZARD)
      else $error("hazard flag missing at 40 V");

   chk_zero_subtract: assert property (
      CONV_VALID && zact && !cap
      |=> s0_data_reg == $past(CONV_DATA) - $past(bsc[23:0]))
      else $error("baseline not subtracted");

   chk_zero_cancel: assert property (
      zkey && zst_reg == ZS_IDLE && zon_reg[fn]
      |=> !zon_reg[$past(fn)] && zst_reg == ZS_IDLE)
      else $error("zero not cancelled");

   chk_zero_capture: assert property (
      cap |=> zstore_reg == $past(CONV_DATA) && zst_reg == ZS_IDLE &&
      base_reg[$past(fn)] == $past(CONV_DATA))
      else $error("baseline not captured");

   chk_base_overrange: assert property (
      CONV_VALID && zact && base_bad |=> s0_over_reg)
      else $error("range below baseline not overranged");

   chk_weight_limits: assert property (
      fw_reg[fn] >= `RZF_FW_MIN && fw_reg[fn] <= `RZF_FW_MAX)
      else $error("filter weight out of limits");

   chk_filter_toggle: assert property (
      fkey |=> filt_en_reg != $past(filt_en_reg))
      else $error("filter key did not toggle");

   chk_lamp_front_only: assert property (
      !filt_en_reg |=> !FILT_LED)
      else $error("filter lamp lit with front filter off");

   chk_oneshot_hold: assert property (
      oneshot_reg && ifr.out_valid && !settled && !CONV_TRIG |=> !OUT_VALID)
      else $error("one-shot output before settling");
endmodule

/* dv/rzf_conv_model.sv */
`timescale 1ns/1ns
module rzf_conv_model
(
   input wire logic clk,
   output logic valid,
   output logic signed [23:0] data,
   output logic over,
   output logic trig
);
   initial
   begin
      valid = 1'b0;
      data = 24'hFFFFFF;
      over = 1'b0;
      trig = 1'b0;
   end
   // one reading after gap + 1 idle cycles; released data is scrambled
   task automatic send(input logic signed [23:0] v, input int gap);
      repeat (gap + 1) @(posedge clk);
      valid <= 1'b1;
      data <= v;
      @(posedge clk);
      valid <= 1'b0;
      data <= ~v;
   endtask
   task automatic kick();
      @(posedge clk);
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
   endtask
endmodule

/* dv/reading_zero_and_filter_tb_top.sv */
`timescale 1ns/1ns
module reading_zero_and_filter_tb_top;
   import rzf_pkg::*;
   typedef struct {logic w; logic [7:0] a; logic [31:0] d, x;} rzf_row_t;
   logic clk, rst, cyc, stb, we, ack, cv, co, ct, ov, oo, haz, zl, fl;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wd, rd, q;
   logic signed [23:0] cd, od, o;
   rzf_func_t fs;
   logic [2:0] rs;
   logic [1:0] res;
   int n_errors = 0;
   int n_compared = 0;
   int n_ov = 0;
   int n_lit;
   rzf_row_t rows [12] = '{'{1'b0, 8'h20, 32'h0, 32'h0A},
      '{1'b0, 8'h00, 32'h0, 32'h08}, '{1'b1, 8'h24, 32'h14, 32'h0},
      '{1'b0, 8'h24, 32'h0, 32'h14}, '{1'b0, 8'h20, 32'h0, 32'h0A},
      '{1'b1, 8'h20, 32'h0, 32'h0}, '{1'b1, 8'h20, 32'h64, 32'h0},
      '{1'b0, 8'h20, 32'h0, 32'h0A}, '{1'b1, 8'h20, 32'h63, 32'h0},
      '{1'b0, 8'h20, 32'h0, 32'h63}, '{1'b1, 8'h20, 32'h02, 32'h0},
      '{1'b0, 8'h10, 32'h0, 32'h0}};
   int hv [4] = '{40, 39, -40, -39};
   rzf_top #(.BLINK_HALF_CYC(4)) DUT (.CORE_CLK(clk), .SYS_RST(rst),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack),
      .CONV_VALID(cv), .CONV_DATA(cd), .CONV_OVER(co), .CONV_TRIG(ct),
      .FUNC_SEL(fs), .RANGE_SEL(rs), .RES_SEL(res), .OUT_VALID(ov),
      .OUT_DATA(od), .OUT_OVER(oo), .HAZARD(haz), .ZERO_LED(zl),
      .FILT_LED(fl));
   rzf_conv_model conv (.clk(clk), .valid(cv), .data(cd), .over(co),
      .trig(ct));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic wrap_up();
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic hang();
      n_errors++;
      $display("mismatch at %0t: no answer", $time);
      wrap_up();
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk);
         if (ack === 1'b1)
            break;
      end
      if (i == 20)
         hang();
      q = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdg(input logic signed [23:0] v, input int gap);
      int i;
      conv.send(v, gap);
      for (i = 0; i < 12 && ov !== 1'b1; i++)
         @(posedge clk);
      if (ov !== 1'b1)
         hang();
      o = od;
   endtask
   // counts output pulses, so withheld one-shot readings can be seen
   always @(posedge clk)
      if (ov === 1'b1)
         n_ov++;
   // lit cycles of a lamp over eight clocks: 4 while blinking
   task automatic lit8(input logic f, output int n);
      n = 0;
      repeat (8)
      begin
         @(posedge clk);
         n += f ? fl : zl;
      end
   endtask
   initial
   begin
      rst = 1'b1;
      {cyc, stb, we, adr, wd} = '0;
      sel = 4'hF;
      fs = FN_DC_VOLTS;
      rs = 3'h0;
      res = 2'h0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({ov, oo, haz, zl, fl, od}, 32'h0);
      $display("reset test done");
      foreach (rows[k])
      begin
         wb(rows[k].w, rows[k].a, rows[k].d);
         if (!rows[k].w)
            chk(q, rows[k].x);
      end
      $display("register test done");
      conv.kick();
      rdg(24'sd100, 0);
      chk(o, 24'sd100);
      wb(1'b1, 8'h00, 32'h09);
      lit8(1'b0, n_lit);
      chk(n_lit, 32'd4);
      rdg(24'sd300, 2);
      chk(o, 24'sd0);
      wb(1'b0, 8'h08, 32'h0);
      chk(q, 32'h12C);
      chk(zl, 1'b1);
      repeat (5) @(posedge clk);
      chk(zl, 1'b1);
      rdg(24'sd350, 0);
      chk(o, 24'sd50);
      fs <= FN_AC_VOLTS;
      rdg(24'sd350, 3);
      chk(o, 24'sd350);
      fs <= FN_DC_VOLTS;
      rdg(24'sd350, 3);
      chk(o, 24'sd50);
      wb(1'b1, 8'h00, 32'h09);
      rdg(24'sd350, 0);
      chk(o, 24'sd350);
      wb(1'b0, 8'h08, 32'h0);
      chk(q, 32'h12C);
      rs <= 3'h1;
      wb(1'b1, 8'h00, 32'h0C);
      rdg(24'sd350, 0);
      chk(o, 24'sd50);
      rs <= 3'h0;
      rdg(24'sd350, 1);
      chk(oo, 1'b1);
      chk(o, -24'sd2650);
      wb(1'b1, 8'h00, 32'h09);
      $display("zero test done");
      wb(1'b1, 8'h00, 32'h0A);
      conv.kick();
      @(posedge clk);
      lit8(1'b1, n_lit);
      chk(n_lit, 32'd4);
      rdg(24'sd500, 0);
      chk(o, 24'sd500);
      rdg(24'sd508, 0);
      chk(o, 24'sd504);
      rdg(24'sd600, 1);
      chk(o, 24'sd600);
      repeat (6) rdg(24'sd600, 0);
      chk(fl, 1'b1);
      repeat (5) @(posedge clk);
      chk(fl, 1'b1);
      rdg(24'sd700, 0);
      lit8(1'b1, n_lit);
      chk(n_lit, 32'd4);
      wb(1'b1, 8'h00, 32'h18);
      conv.kick();
      n_lit = n_ov;
      repeat (5) conv.send(24'sd600, 0);
      repeat (8) @(posedge clk);
      chk(n_ov - n_lit, 32'd0);
      rdg(24'sd600, 0);
      chk(o, 24'sd600);
      wb(1'b1, 8'h00, 32'h0A);
      @(posedge clk);
      chk(fl, 1'b0);
      $display("filter test done");
      wb(1'b0, 8'h04, 32'h0);
      chk(q & 32'h10, 32'h0);
      res <= 2'h3;
      wb(1'b0, 8'h04, 32'h0);
      chk(q & 32'h10, 32'h10);
      chk(fl, 1'b0);
      wb(1'b1, 8'h00, 32'h00);
      wb(1'b0, 8'h04, 32'h0);
      chk(q & 32'h10, 32'h0);
      wb(1'b1, 8'h00, 32'h08);
      $display("internal filter test done");
      res <= 2'h0;
      rs <= 3'h4;
      foreach (hv[k])
      begin
         rdg(24'(hv[k]), 1);
         chk(haz, (k % 2) == 0);
      end
      rdg(24'sd2201, 1);
      chk(oo, 1'b1);
      rdg(24'sd2200, 1);
      chk(oo, 1'b0);
      $display("hazard test done");
      wrap_up();
   end
endmodule
